// *** design/pkm_pin_mux.sv ***
// Purpose: pin function mux for ports K, M, P, S and T
// Assumes: peripherals sit on sys_clk; pads are asynchronous
// Notes:   each pin: fixed priority over functions, gpio lowest
// Function
// - unselected pins act as plain gpio
// - expanded mode: K7 drives chip select
// - reset release latches K7 into flash bit
// - expanded mode: K5..K0 carry address 19..14
// - M7: slot mismatch pulse or can4 tx
// - M6: format error pulse or can4 rx
// - M5: reception ok, can0/4 tx, spi0 sck
// - M4: sync ok, can0/4 rx, spi0 mosi
// - M3: tt tx, can1/0 tx, spi0 ss
// - M2: tt rx, can1/0 rx, spi0 miso
// - M1: can0 tx or datalink tx
// - M0: can0 rx or datalink rx
// - port P pins raise wake-up interrupts
// - P pin n carries pwm channel n
// - P3..P0 carry spi1 ss sck mosi miso
// - S7..S4 carry spi0 ss sck mosi miso
// - S3..S0 carry serial unit 1 and 0
// - T pin n serves timer channel n
// - flash bit set makes flash visible
// - mode taken from pins at reset release
`timescale 1ns/1ns
module pkm_pin_mux
    import pkm_pkg::*;
#(
    parameter int PW = PORT_W
)(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // pads
    input  wire logic [PW-1:0]     pk_in,
    input  wire logic [PW-1:0]     pm_in,
    input  wire logic [PW-1:0]     pp_in,
    input  wire logic [PW-1:0]     ps_in,
    input  wire logic [PW-1:0]     pt_in,
    input  wire logic              mode_select_c,
    input  wire logic              mode_select_b,
    input  wire logic              mode_select_a,
    output logic [PW-1:0]          pk_out,
    output logic [PW-1:0]          pk_oe,
    output logic [PW-1:0]          pm_out,
    output logic [PW-1:0]          pm_oe,
    output logic [PW-1:0]          pp_out,
    output logic [PW-1:0]          pp_oe,
    output logic [PW-1:0]          ps_out,
    output logic [PW-1:0]          ps_oe,
    output logic [PW-1:0]          pt_out,
    output logic [PW-1:0]          pt_oe,
    // gpio register side, one struct per port
    input  wire pkm_periph_t       gpio_k,
    input  wire pkm_periph_t       gpio_m,
    input  wire pkm_periph_t       gpio_p,
    input  wire pkm_periph_t       gpio_s,
    input  wire pkm_periph_t       gpio_t,
    output logic [PW-1:0]          pk_pad_lvl,
    output logic [PW-1:0]          pm_pad_lvl,
    output logic [PW-1:0]          pp_pad_lvl,
    output logic [PW-1:0]          ps_pad_lvl,
    output logic [PW-1:0]          pt_pad_lvl,
    // expanded bus
    input  wire logic              emulation_chip_select_n,
    input  wire logic [EXTENDED_ADDRESS_HI:EXTENDED_ADDRESS_LO] extended_address,
    output logic [2:0]             mode_latched,
    output logic                   flash_visible_bit,
    // time-triggered bus controller
    input  wire logic              tt_en,
    input  wire logic              tt_slot_mismatch_pulse,
    input  wire logic              tt_format_error_pulse,
    input  wire logic              tt_reception_ok_pulse,
    input  wire logic              tt_sync_ok_pulse,
    input  wire logic              tt_bus_tx,
    output logic                   tt_bus_rx,
    // can controllers: [0]=can0 [1]=can1 [2]=can4
    input  wire logic [2:0]        can_en,
    input  wire logic              can0_on_m54,
    input  wire logic              can0_on_m32,
    input  wire logic [2:0]        can_tx_line,
    output logic [2:0]             can_rx_line,
    // serial datalink
    input  wire logic              serial_datalink_ctrl_en,
    input  wire logic              datalink_tx,
    output logic                   datalink_rx,
    // spi units: bit 0 unit0 on M, bit 1 unit0 on S, bit 2 unit1 on P
    input  wire logic [2:0]        spi_route_en,
    input  wire pkm_periph_t       spi0_io,
    input  wire pkm_periph_t       spi1_io,
    output logic [3:0]             spi0_in,
    output logic [3:0]             spi1_in,
    // pwm, timer, serial units, wake-up
    input  wire pkm_periph_t       pwm_io,
    input  wire pkm_periph_t       timer_io,
    output logic [PW-1:0]          capture_compare_channel,
    input  wire logic [1:0]        async_serial_unit_en,
    input  wire logic [1:0]        async_serial_unit_tx,
    output logic [1:0]             async_serial_unit_rx,
    input  wire logic [PW-1:0]     wake_en,
    output logic                   portp_wakeup_irq
);

    if (PW != PORT_W)
    begin : g_bad_width
        $error("pkm_pin_mux: pin map fixed at eight pins per port");
    end

    // ************************************************************
    // pad synchronisers: second stage only is read
    // ************************************************************
    logic [PW-1:0] k_s1_q, m_s1_q, p_s1_q, s_s1_q, t_s1_q;
    logic [PW-1:0] k_s2_q, m_s2_q, p_s2_q, s_s2_q, t_s2_q;
    logic [2:0]    md_s1_q, md_s2_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {k_s1_q, m_s1_q, p_s1_q, s_s1_q, t_s1_q} <= '0;
            {k_s2_q, m_s2_q, p_s2_q, s_s2_q, t_s2_q} <= '0;
            md_s1_q <= MODE_RESET_VAL;
            md_s2_q <= MODE_RESET_VAL;
        end
        else
        begin
            {k_s1_q, m_s1_q, p_s1_q, s_s1_q, t_s1_q} <= {pk_in, pm_in, pp_in, ps_in, pt_in};
            {k_s2_q, m_s2_q, p_s2_q, s_s2_q, t_s2_q} <= {k_s1_q, m_s1_q, p_s1_q, s_s1_q, t_s1_q};
            md_s1_q <= {mode_select_c, mode_select_b, mode_select_a};
            md_s2_q <= md_s1_q;
        end
    end

    // ************************************************************
    // straps: caught once, first clocked cycle after sync settles
    // ************************************************************
    logic [1:0] strap_cnt_q;
    logic       strap_done_q;
    logic [2:0] mode_q;
    logic       flash_q;

    // waits two edges so the synchronisers hold real pad levels
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_cnt_q  <= 2'h0;
            strap_done_q <= 1'b0;
            mode_q       <= MODE_RESET_VAL;
            flash_q      <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            if (strap_cnt_q == 2'h2)
            begin
                strap_done_q <= 1'b1;
                mode_q       <= md_s2_q;
                flash_q      <= k_s2_q[PK_ECS_BIT];
            end
            else
                strap_cnt_q <= strap_cnt_q + 2'h1;
        end
    end

    assign mode_latched      = mode_q;
    assign flash_visible_bit = flash_q;

    wire exp_mode = strap_done_q && mode_q[MODE_EXP_BIT];

    // ************************************************************
    // per-pin request tables, index 0 is highest priority
    // ************************************************************
    localparam int NR = 4;
    logic [NR-1:0] k_en [PW], k_o [PW], k_oe [PW];
    logic [NR-1:0] m_en [PW], m_o [PW], m_oe [PW];
    logic [NR-1:0] p_en [PW], p_o [PW], p_oe [PW];
    logic [NR-1:0] s_en [PW], s_o [PW], s_oe [PW];
    logic [NR-1:0] t_en [PW], t_o [PW], t_oe [PW];

    wire spi0m = spi_route_en[0];
    wire spi0s = spi_route_en[1];
    wire spi1p = spi_route_en[2];
    wire cm_a  = can_en[0] && can0_on_m54;
    wire c4_m  = can_en[2];
    wire c0_m10 = can_en[0] && !can0_on_m54 && !can0_on_m32;

    always_comb
    begin
        for (int i = 0; i < PW; i++)
        begin
            {k_en[i], k_o[i], k_oe[i]} = '0;
            {m_en[i], m_o[i], m_oe[i]} = '0;
            {p_en[i], p_o[i], p_oe[i]} = '0;
            {s_en[i], s_o[i], s_oe[i]} = '0;
            // timer channel n on pin n
            t_en[i] = {3'h0, timer_io.en[i]};
            t_o[i]  = {3'h0, timer_io.out[i]};
            t_oe[i] = {3'h0, timer_io.oe[i]};
            // pwm is lowest peripheral on port P, spi1 wins above it
            p_en[i][1] = pwm_io.en[i];
            p_o[i][1]  = pwm_io.out[i];
            p_oe[i][1] = 1'b1;
        end
        // expanded bus on port K
        k_en[PK_ECS_BIT] = {3'h0, exp_mode};
        k_o[PK_ECS_BIT]  = {3'h0, emulation_chip_select_n};
        k_oe[PK_ECS_BIT] = {3'h0, 1'b1};
        for (int i = 0; i <= PK_XA_HI; i++)
        begin
            k_en[i] = {3'h0, exp_mode};
            k_o[i]  = {3'h0, extended_address[EXTENDED_ADDRESS_LO + i]};
            k_oe[i] = {3'h0, 1'b1};
        end
        // port M: tt > can > spi0 > datalink
        m_en[7] = {2'h0, c4_m, tt_en};
        m_o[7]  = {2'h0, can_tx_line[2], tt_slot_mismatch_pulse};
        m_oe[7] = {2'h0, 2'h3};
        m_en[6] = {2'h0, c4_m, tt_en};
        m_o[6]  = {2'h0, 1'b0, tt_format_error_pulse};
        m_oe[6] = {2'h0, 2'h1};
        m_en[5] = {1'h0, spi0m, can_en[2] | cm_a, tt_en};
        m_o[5]  = {1'h0, spi0_io.out[1], cm_a ? can_tx_line[0] : can_tx_line[2],
                   tt_reception_ok_pulse};
        m_oe[5] = {1'h0, spi0_io.oe[1], 2'h3};
        m_en[4] = {1'h0, spi0m, can_en[2] | cm_a, tt_en};
        m_o[4]  = {1'h0, spi0_io.out[2], 1'b0, tt_sync_ok_pulse};
        m_oe[4] = {1'h0, spi0_io.oe[2], 2'h1};
        m_en[3] = {1'h0, spi0m, can_en[1] | (can_en[0] && can0_on_m32), tt_en};
        m_o[3]  = {1'h0, spi0_io.out[0], can_en[1] ? can_tx_line[1] : can_tx_line[0],
                   tt_bus_tx};
        m_oe[3] = {1'h0, spi0_io.oe[0], 2'h3};
        m_en[2] = {1'h0, spi0m, can_en[1] | (can_en[0] && can0_on_m32), tt_en};
        m_o[2]  = {1'h0, spi0_io.out[3], 2'h0};
        m_oe[2] = {1'h0, spi0_io.oe[3], 2'h0};
        m_en[1] = {2'h0, serial_datalink_ctrl_en,
                   can_en[0] && !can0_on_m54 && !can0_on_m32};
        m_o[1]  = {2'h0, datalink_tx, can_tx_line[0]};
        m_oe[1] = {2'h0, 2'h3};
        m_en[0] = {2'h0, serial_datalink_ctrl_en,
                   can_en[0] && !can0_on_m54 && !can0_on_m32};
        // port P: spi1 on pins 3..0 above pwm, order ss sck mosi miso
        for (int i = 0; i < 4; i++)
        begin
            p_en[i][0] = spi1p;
            p_o[i][0]  = spi1_io.out[3 - i];
            p_oe[i][0] = spi1_io.oe[3 - i];
        end
        // port S: spi0 on 7..4, serial units on 3..0
        for (int i = 0; i < 4; i++)
        begin
            s_en[4 + i] = {3'h0, spi0s};
            s_o[4 + i]  = {3'h0, spi0_io.out[3 - i]};
            s_oe[4 + i] = {3'h0, spi0_io.oe[3 - i]};
        end
        s_en[3] = {3'h0, async_serial_unit_en[1]};
        s_o[3]  = {3'h0, async_serial_unit_tx[1]};
        s_oe[3] = {3'h0, 1'b1};
        s_en[2] = {3'h0, async_serial_unit_en[1]};
        s_en[1] = {3'h0, async_serial_unit_en[0]};
        s_o[1]  = {3'h0, async_serial_unit_tx[0]};
        s_oe[1] = {3'h0, 1'b1};
        s_en[0] = {3'h0, async_serial_unit_en[0]};
    end

    // ************************************************************
    // one registered pad cell per pin
    // ************************************************************
    for (genvar g = 0; g < PW; g++)
    begin : g_pin
        pkm_pin_cell #(.N_REQ(NR)) u_k (
            .sys_clk(sys_clk), .rst_n(rst_n), .req_en(k_en[g]), .req_out(k_o[g]),
            .req_oe(k_oe[g]), .gpio_out(gpio_k.out[g]), .gpio_oe(gpio_k.oe[g]),
            .pad_out(pk_out[g]), .pad_oe(pk_oe[g]));
        pkm_pin_cell #(.N_REQ(NR)) u_m (
            .sys_clk(sys_clk), .rst_n(rst_n), .req_en(m_en[g]), .req_out(m_o[g]),
            .req_oe(m_oe[g]), .gpio_out(gpio_m.out[g]), .gpio_oe(gpio_m.oe[g]),
            .pad_out(pm_out[g]), .pad_oe(pm_oe[g]));
        pkm_pin_cell #(.N_REQ(NR)) u_p (
            .sys_clk(sys_clk), .rst_n(rst_n), .req_en(p_en[g]), .req_out(p_o[g]),
            .req_oe(p_oe[g]), .gpio_out(gpio_p.out[g]), .gpio_oe(gpio_p.oe[g]),
            .pad_out(pp_out[g]), .pad_oe(pp_oe[g]));
        pkm_pin_cell #(.N_REQ(NR)) u_s (
            .sys_clk(sys_clk), .rst_n(rst_n), .req_en(s_en[g]), .req_out(s_o[g]),
            .req_oe(s_oe[g]), .gpio_out(gpio_s.out[g]), .gpio_oe(gpio_s.oe[g]),
            .pad_out(ps_out[g]), .pad_oe(ps_oe[g]));
        pkm_pin_cell #(.N_REQ(NR)) u_t (
            .sys_clk(sys_clk), .rst_n(rst_n), .req_en(t_en[g]), .req_out(t_o[g]),
            .req_oe(t_oe[g]), .gpio_out(gpio_t.out[g]), .gpio_oe(gpio_t.oe[g]),
            .pad_out(pt_out[g]), .pad_oe(pt_oe[g]));
    end

    // ************************************************************
    // input forwarding, registered, and port P wake-up
    // ************************************************************
    logic [PW-1:0] p_prev_q;
    logic          wake_q;

    // tt, can1 and datalink rx idle high when their pin is not routed, can4 rx while tt is on; can0, spi and serial rx always follow their pins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {pk_pad_lvl, pm_pad_lvl, pp_pad_lvl, ps_pad_lvl, pt_pad_lvl} <= '0;
            tt_bus_rx               <= 1'b1;
            can_rx_line             <= 3'h7;
            datalink_rx             <= 1'b1;
            spi0_in                 <= 4'h0;
            spi1_in                 <= 4'h0;
            capture_compare_channel <= '0;
            async_serial_unit_rx    <= 2'h3;
            p_prev_q                <= '0;
            wake_q                  <= 1'b0;
        end
        else
        begin
            {pk_pad_lvl, pm_pad_lvl, pp_pad_lvl, ps_pad_lvl, pt_pad_lvl}
                <= {k_s2_q, m_s2_q, p_s2_q, s_s2_q, t_s2_q};
            tt_bus_rx <= tt_en ? m_s2_q[2] : 1'b1;
            can_rx_line[2] <= tt_en ? 1'b1 : (m_s2_q[6] & (cm_a ? 1'b1 : m_s2_q[4]));
            can_rx_line[1] <= (can_en[1] && !tt_en) ? m_s2_q[2] : 1'b1;
            can_rx_line[0] <= cm_a ? m_s2_q[4] :
                              can0_on_m32 ? m_s2_q[2] : m_s2_q[0];
            datalink_rx <= (serial_datalink_ctrl_en && !c0_m10) ? m_s2_q[0] : 1'b1;
            spi0_in <= spi0s ? {s_s2_q[4], s_s2_q[5], s_s2_q[6], s_s2_q[7]}
                             : {m_s2_q[2], m_s2_q[4], m_s2_q[5], m_s2_q[3]};
            spi1_in <= {p_s2_q[0], p_s2_q[1], p_s2_q[2], p_s2_q[3]};
            capture_compare_channel <= t_s2_q;
            async_serial_unit_rx <= {s_s2_q[2], s_s2_q[0]};
            p_prev_q <= p_s2_q;
            // held off until sync settles, else reset release looks like an edge
            wake_q <= strap_done_q && (|((p_s2_q ^ p_prev_q) & wake_en));
        end
    end

    assign portp_wakeup_irq = wake_q;

    // ************************************************************
    // checks
    // ************************************************************
    exp_ecs_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exp_mode |=> pk_oe[PK_ECS_BIT] && pk_out[PK_ECS_BIT] == $past(emulation_chip_select_n))
        else $error("chip select not on K7");
    extended_address_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        exp_mode |=> pk_out[PK_XA_HI:0] == $past(extended_address))
        else $error("address not on K5..K0");
    tt_prio_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tt_en |=> pm_out[7] == $past(tt_slot_mismatch_pulse))
        else $error("tt pulse lost priority");
    gpio_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (timer_io.en == '0) |=> pt_out == $past(gpio_t.out) && pt_oe == $past(gpio_t.oe))
        else $error("gpio not passed through");
    pwm_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pwm_io.en[6] |=> pp_out[6] == $past(pwm_io.out[6]) && pp_oe[6])
        else $error("pwm6 not on P6");
    spi1_win_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (spi1p && pwm_io.en[0]) |=> pp_oe[0] == $past(spi1_io.oe[3]))
        else $error("spi1 not above pwm");
    strap_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strap_done_q |=> $stable(flash_visible_bit) && $stable(mode_latched))
        else $error("strap changed after capture");
    wake_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (strap_done_q && |(($past(p_s2_q) ^ p_s2_q) & wake_en)) |=> portp_wakeup_irq)
        else $error("wake-up missed");
    sci_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        async_serial_unit_en[1] |=> ps_out[3] == $past(async_serial_unit_tx[1]))
        else $error("serial unit 1 tx not on S3");

endmodule : pkm_pin_mux

// *** design/pkm_pkg.sv ***
// Purpose: shared types and constants for the port K/M/P/S/T pin mux
// Assumes: one bus clock, asynchronous active-low reset
// Notes:   per-pin selection codes live here so the mux and bench agree
package pkm_pkg;

    // ************************************************************
    // widths and mode encodings
    // ************************************************************
    localparam int PORT_W = 8;

    // three latched mode pins {c,b,a}; expanded modes have mode_select_a set
    localparam logic [2:0] MODE_RESET_VAL = 3'h0;
    localparam int         MODE_EXP_BIT   = 0;

    // port K field positions
    localparam int PK_ECS_BIT = 7;
    localparam int PK_XA_HI   = 5;
    localparam int EXTENDED_ADDRESS_HI   = 19;
    localparam int EXTENDED_ADDRESS_LO   = 14;

    // port M per-pin selections, gpio first, then highest priority first within a pin
    typedef enum logic [2:0] {
        PKM_SEL_GPIO,
        PKM_SEL_TT,
        PKM_SEL_CAN_A,
        PKM_SEL_CAN_B,
        PKM_SEL_SPI0,
        PKM_SEL_DLINK
    } pkm_sel_t;

    // one pad's worth of drive
    typedef struct packed {
        logic out;
        logic oe;
    } pkm_drive_t;

    // peripheral output bundle for one 8-bit port
    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
        logic [PORT_W-1:0] en;
    } pkm_periph_t;

endpackage : pkm_pkg

// *** design/pkm_pin_cell.sv ***
// Purpose: one pad slice: priority pick of up to eight requests over gpio
// Assumes: requests come from same-clock logic, the pad input is already synchronised
// Notes:   registered drive so top-level outputs come straight from flops
`timescale 1ns/1ns
module pkm_pin_cell
    import pkm_pkg::*;
#(
    parameter int N_REQ = 4
)(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [N_REQ-1:0] req_en,
    input  wire logic [N_REQ-1:0] req_out,
    input  wire logic [N_REQ-1:0] req_oe,
    input  wire logic             gpio_out,
    input  wire logic             gpio_oe,
    output logic                  pad_out,
    output logic                  pad_oe
);

    // refused at elaboration: the pick is unrolled per request
    if (N_REQ < 1 || N_REQ > 8)
    begin : g_bad_req
        $error("pkm_pin_cell: N_REQ out of range");
    end

    // ************************************************************
    // priority pick, index 0 wins, gpio last
    // ************************************************************
    pkm_drive_t drv_d;

    always_comb
    begin
        drv_d.out = gpio_out;
        drv_d.oe  = gpio_oe;
        for (int i = N_REQ - 1; i >= 0; i--)
        begin
            if (req_en[i])
            begin
                drv_d.out = req_out[i];
                drv_d.oe  = req_oe[i];
            end
        end
    end

    // registered so glitches of the pick never reach the pad
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end
        else
        begin
            pad_out <= drv_d.out;
            pad_oe  <= drv_d.oe;
        end
    end

endmodule : pkm_pin_cell

// *** verif/pkm_pad_model.sv ***
// Purpose: pad wire model for one 8-bit port
// Assumes: the outside level acts as a pull while a pin is released
// Notes:   a released pin never keeps showing its last drive
`timescale 1ns/1ns
module pkm_pad_model
(
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] ext_lvl,
    output logic      [7:0] pad_lvl
);
    // driven pins show the drive, released pins fall to the pull level
    assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : pkm_pad_model

// *** verif/port_kmpst_pin_function_mux_tb.sv ***
// Purpose: self-checking bench for the port K/M/P/S/T pin mux
// Assumes: latencies as handed over, inputs change on falling edges
// Notes:   unchecked bits are masked where their drive is left open
`timescale 1ns/1ns
module port_kmpst_pin_function_mux_tb;
    import pkm_pkg::*;
    logic        sys_clk, rst_n, msc, msb, msa, ecs_n, tt_en, dl_en, dl_tx, c54, c32, irq;
    logic        tt_rx, dl_rx, flash;
    logic [4:0]  tt_v;
    logic [5:0]  xa;
    logic [2:0]  can_en, can_tx, can_rx, spi_rt, mode;
    logic [1:0]  sci_en, sci_tx, sci_rx;
    logic [3:0]  s0_in, s1_in;
    logic [7:0]  k_x, m_x, p_x, s_x, t_x, k_w, m_w, p_w, s_w, t_w, wk_en, cap;
    logic [7:0]  k_o, k_e, m_o, m_e, p_o, p_e, s_o, s_e, t_o, t_e, k_l, m_l, p_l, s_l, t_l;
    pkm_periph_t gk, gm, gp, gs, gt, spi0, spi1, pwm, tmr;
    int          failures, checks, n;

    // 250 MHz bus clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // outside world of each port
    pkm_pad_model pad_k (.pad_out(k_o), .pad_oe(k_e), .ext_lvl(k_x), .pad_lvl(k_w));
    pkm_pad_model pad_m (.pad_out(m_o), .pad_oe(m_e), .ext_lvl(m_x), .pad_lvl(m_w));
    pkm_pad_model pad_p (.pad_out(p_o), .pad_oe(p_e), .ext_lvl(p_x), .pad_lvl(p_w));
    pkm_pad_model pad_s (.pad_out(s_o), .pad_oe(s_e), .ext_lvl(s_x), .pad_lvl(s_w));
    pkm_pad_model pad_t (.pad_out(t_o), .pad_oe(t_e), .ext_lvl(t_x), .pad_lvl(t_w));

    pkm_pin_mux dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .pk_in(k_w), .pm_in(m_w), .pp_in(p_w), .ps_in(s_w),
        .pt_in(t_w), .mode_select_c(msc), .mode_select_b(msb), .mode_select_a(msa),
        .pk_out(k_o), .pk_oe(k_e), .pm_out(m_o), .pm_oe(m_e), .pp_out(p_o), .pp_oe(p_e),
        .ps_out(s_o), .ps_oe(s_e), .pt_out(t_o), .pt_oe(t_e), .gpio_k(gk), .gpio_m(gm),
        .gpio_p(gp), .gpio_s(gs), .gpio_t(gt), .pk_pad_lvl(k_l), .pm_pad_lvl(m_l),
        .pp_pad_lvl(p_l), .ps_pad_lvl(s_l), .pt_pad_lvl(t_l), .emulation_chip_select_n(ecs_n),
        .extended_address(xa), .mode_latched(mode), .flash_visible_bit(flash), .tt_en(tt_en),
        .tt_slot_mismatch_pulse(tt_v[4]), .tt_format_error_pulse(tt_v[3]),
        .tt_reception_ok_pulse(tt_v[2]), .tt_sync_ok_pulse(tt_v[1]), .tt_bus_tx(tt_v[0]),
        .tt_bus_rx(tt_rx), .can_en(can_en), .can0_on_m54(c54), .can0_on_m32(c32),
        .can_tx_line(can_tx), .can_rx_line(can_rx), .serial_datalink_ctrl_en(dl_en),
        .datalink_tx(dl_tx), .datalink_rx(dl_rx), .spi_route_en(spi_rt), .spi0_io(spi0),
        .spi1_io(spi1), .spi0_in(s0_in), .spi1_in(s1_in), .pwm_io(pwm), .timer_io(tmr),
        .capture_compare_channel(cap), .async_serial_unit_en(sci_en),
        .async_serial_unit_tx(sci_tx), .async_serial_unit_rx(sci_rx), .wake_en(wk_en),
        .portp_wakeup_irq(irq)
    );

    // ************
    // checks
    // ************
    task automatic cyc(input int c);
        repeat (c) @(negedge sys_clk);
    endtask : cyc

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic gchk(input string nm, input logic [7:0] o, e, l);
        chk(nm, 8'hA0, o & 8'hF0);
        chk(nm, 8'hF0, e);
        chk(nm, 8'hAC, l);
    endtask : gchk

    // straps are held across the release so the latch sees a settled level
    task automatic rst(input logic exp_mode, input logic strap);
        rst_n = 1'b0;
        msa = exp_mode;
        k_x[7] = strap;
        cyc(20);
        rst_n = 1'b1;
        cyc(6);
        chk("mode_latched", {7'h00, exp_mode}, {5'h00, mode});
        chk("flash_visible_bit", {7'h00, strap}, {7'h00, flash});
    endtask : rst

    // one sample per cycle, so a one-cycle pulse counts once
    task automatic count_irq(output int cnt);
        cnt = 0;
        repeat (8)
        begin
            @(negedge sys_clk);
            if (irq === 1'b1)
                cnt++;
        end
    endtask : count_irq

    task automatic report_and_stop;
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // main sequence
    initial
    begin
        {rst_n, msc, msb, msa, ecs_n, tt_en, dl_en, dl_tx, c54, c32, tt_v, xa} = '0;
        {can_en, can_tx, spi_rt, sci_en, sci_tx, wk_en, failures, checks} = '0;
        {k_x, m_x, p_x, s_x, t_x, gk, gm, gp, gs, gt, spi0, spi1, pwm, tmr} = '0;
        rst(1'b1, 1'b1);
        {ecs_n, xa} = {1'b1, 6'h2D};
        cyc(2);
        chk("pk_out", 8'hAD, k_o & 8'hBF);
        chk("pk_oe", 8'hBF, k_e & 8'hBF);
        {gk, ecs_n, xa} = {24'hFFFF00, 1'b0, 6'h12};
        cyc(2);
        chk("pk_out", 8'h52, k_o);
        rst(1'b0, 1'b0);
        {gk, gm, gp, gs, gt} = {5{24'hA5F000}};
        {k_x, m_x, p_x, s_x, t_x} = {5{8'h0C}};
        cyc(5);
        gchk("port_k", k_o, k_e, k_l);
        gchk("port_m", m_o, m_e, m_l);
        gchk("port_p", p_o, p_e, p_l);
        gchk("port_s", s_o, s_e, s_l);
        gchk("port_t", t_o, t_e, t_l);
        {gk, gp, gs, gt, k_x, m_x, p_x, s_x, t_x} = '0;
        gm = {8'hFF, 8'hFF, 8'h00};
        {tt_en, tt_v, can_en, can_tx, spi_rt, dl_en} = {1'b1, 5'b10110, 9'o717, 1'b1};
        cyc(5);
        chk("pm_out", 8'hB2, m_o & 8'hFA);
        chk("pm_oe", 8'hFA, m_e);
        chk("tt_bus_rx", 8'h00, {7'h00, tt_rx});
        {tt_en, can_tx, m_x} = {1'b0, 3'b110, 8'h44};
        cyc(5);
        chk("pm_out", 8'h88, m_o & 8'h8A);
        chk("pm_oe", 8'h8A, m_e & 8'hCF);
        chk("can_rx_line", 8'h02, {5'h00, can_rx});
        {can_en, dl_tx, spi0, spi1} = {4'h1, 24'h06070F, 24'h090E0F};
        {pwm, tmr} = {24'hF0FF7F, 24'h3C0FFF};
        {sci_en, sci_tx, s_x, p_x, t_x, wk_en} = {4'hD, 32'h0408A080};
        cyc(5);
        chk("pm_out", 8'h32, m_o & 8'h3A);
        chk("pm_oe", 8'h3A, m_e & 8'h3F);
        chk("datalink_rx", 8'h00, {7'h00, dl_rx});
        chk("ps_out", 8'h62, s_o & 8'hFA);
        chk("ps_oe", 8'hEA, s_e);
        chk("serial_rx", 8'h02, {6'h00, sci_rx});
        chk("spi0_in", 8'h06, {4'h0, s0_in});
        chk("pp_out", 8'h79, p_o & 8'h7F);
        chk("pp_oe", 8'h77, p_e & 8'h7F);
        chk("spi1_in", 8'h09, {4'h0, s1_in});
        chk("pt_out", 8'h0C, t_o & 8'h0F);
        chk("pt_oe", 8'h0F, t_e);
        chk("capture", 8'hAC, cap);
        p_x[3] = 1'b0;
        count_irq(n);
        chk("wake_masked", 8'h00, n[7:0]);
        p_x[7] = 1'b1;
        count_irq(n);
        chk("wake_pulses", 8'h01, n[7:0]);
        {can_en, c54, can_tx} = {3'h1, 1'b1, 3'h1};
        cyc(5);
        chk("pm_out", 8'h22, m_o & 8'h32);
        chk("pm_oe", 8'h22, m_e & 8'h33);
        chk("can_rx_line", 8'h06, {5'h00, can_rx});
        chk("datalink_rx", 8'h00, {7'h00, dl_rx});
        {c54, c32, m_x} = {2'b01, 8'h40};
        cyc(5);
        chk("pm_out", 8'h0A, m_o & 8'h0E);
        chk("can_rx_line", 8'h06, {5'h00, can_rx});
        chk("datalink_rx", 8'h00, {7'h00, dl_rx});
        report_and_stop();
    end
endmodule : port_kmpst_pin_function_mux_tb
